// [inc/mcts_pkg.sv]
// Purpose: Shared constants and types of the main clock and tick controller
// Assumes: One 8-bit control/status register plus interrupt and mode registers
// Notes: Register indices are word indices; byte address is four times the index
package mcts_pkg;

  // Avalon-MM geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned IDX_W = 6;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned BE_W = 4;
  localparam logic [1:0] ADDR_LSB_ZERO = 2'h0;

  // Register indices
  localparam logic [IDX_W-1:0] CSR_IDX = 6'h2e;
  localparam logic [IDX_W-1:0] IRQ_STAT_IDX = 6'h31;
  localparam logic [IDX_W-1:0] IRQ_CLR_IDX = 6'h32;
  localparam logic [IDX_W-1:0] IRQ_EN_IDX = 6'h33;
  localparam logic [IDX_W-1:0] PMODE_IDX = 6'h34;

  // Control/status register layout, high bit first
  typedef struct packed {
    logic       clock_out_enable;
    logic [1:0] cpu_slow_divider_select;
    logic       slow_mode_select;
    logic [1:0] time_base_select;
    logic       tick_interrupt_enable;
    logic       tick_flag;
  } mcts_csr_t;

  localparam logic [7:0] CSR_RST = 8'h00;

  // Interrupt status layout
  localparam int unsigned IRQ_W = 2;
  localparam int unsigned IRQ_TICK_BIT = 0;
  localparam int unsigned IRQ_WAKE_BIT = 1;
  localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;

  // CPU prescaler end-of-count values
  localparam int unsigned CPU_DIV_W = 4;
  localparam logic [CPU_DIV_W-1:0] CPU_DIV1_LIM = 4'h0;
  localparam logic [CPU_DIV_W-1:0] CPU_DIV2_LIM = 4'h1;
  localparam logic [CPU_DIV_W-1:0] CPU_DIV4_LIM = 4'h3;
  localparam logic [CPU_DIV_W-1:0] CPU_DIV8_LIM = 4'h7;
  localparam logic [CPU_DIV_W-1:0] CPU_DIV16_LIM = 4'hf;

  // Tick periods in oscillator cycles
  localparam int unsigned TICK_W = 18;
  localparam int unsigned TB0_CYC = 16000;
  localparam int unsigned TB1_CYC = 32000;
  localparam int unsigned TB2_CYC = 80000;
  localparam int unsigned TB3_CYC = 200000;

  // Power modes
  typedef enum logic [2:0] {
    PM_RUN  = 3'b000,
    PM_WAIT = 3'b001,
    PM_DEEP = 3'b010,
    PM_HALT = 3'b011,
    PM_AWU  = 3'b100
  } mcts_pmode_t;

  // Bus request bundle
  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic              read;
    logic              write;
    logic [DATA_W-1:0] writedata;
    logic [BE_W-1:0]   byteenable;
  } mcts_bus_req_t;

endpackage

// [hw/mcts_div.sv]
// Purpose: Free-running divider that flags the last cycle of each count
// Assumes: Limit may change at any time; a count past it wraps at once
// Notes: Count holds while run_in is low
module mcts_div #(
  parameter int unsigned W = 4
) (
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic run_in,
  input wire logic [W-1:0] limit_in,
  output logic end_out
);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  assign end_out = run_in && (cnt_r >= limit_in);

  always_comb begin
    cnt_nxt = cnt_r;
    if (end_out) begin
      cnt_nxt = '0;
    end else if (run_in) begin
      cnt_nxt = cnt_r + W'(1);
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule // mcts_div

// [hw/mcts_top.sv]
// Purpose: Main clock controller with CPU prescaler, clock-out and tick timer
// Assumes: core_clk_in is the oscillator clock; CPU mode strobes are on this clock
// Notes: The CPU clock leaves as a one-cycle enable per divided period
//
// Our own choice: the Avalon-MM slave port.
module mcts_top #(
  parameter int unsigned TB0_CYC = mcts_pkg::TB0_CYC,
  parameter int unsigned TB1_CYC = mcts_pkg::TB1_CYC,
  parameter int unsigned TB2_CYC = mcts_pkg::TB2_CYC,
  parameter int unsigned TB3_CYC = mcts_pkg::TB3_CYC
) (
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic [mcts_pkg::ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [mcts_pkg::DATA_W-1:0] avs_writedata_in,
  input wire logic [mcts_pkg::BE_W-1:0] avs_byteenable_in,
  output logic [mcts_pkg::DATA_W-1:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic wait_exec_in,
  input wire logic halt_exec_in,
  input wire logic awu_halt_exec_in,
  input wire logic other_irq_in,
  input wire logic halt_wake_in,
  input wire logic gpio_pin_data_in,
  input wire logic gpio_pin_oe_in,
  output logic clk_pin_out,
  output logic clk_pin_oe_out,
  output logic cpu_clk_en_out,
  output logic periph_clk_en_out,
  output logic tick_req_out,
  output logic irq_out,
  output mcts_pkg::mcts_pmode_t power_mode_out
);

  // Bus request bundle
  mcts_pkg::mcts_bus_req_t req;
  assign req = '{address: avs_address_in, read: avs_read_in, write: avs_write_in,
                 writedata: avs_writedata_in, byteenable: avs_byteenable_in};

  // Registered state
  mcts_pkg::mcts_csr_t csr_r;
  mcts_pkg::mcts_csr_t csr_nxt;
  logic [1:0] active_tb_r;
  logic [1:0] active_tb_nxt;
  logic [mcts_pkg::IRQ_W-1:0] irq_stat_r;
  logic [mcts_pkg::IRQ_W-1:0] irq_stat_nxt;
  logic [mcts_pkg::IRQ_W-1:0] irq_en_r;
  logic [mcts_pkg::IRQ_W-1:0] irq_en_nxt;
  mcts_pkg::mcts_pmode_t mode_r;
  mcts_pkg::mcts_pmode_t mode_nxt;
  logic ack_r;
  logic ack_nxt;
  logic [mcts_pkg::DATA_W-1:0] rdata_r;
  logic [mcts_pkg::DATA_W-1:0] rdata_nxt;
  logic cpu_en_r;
  logic cpu_en_nxt;
  logic periph_en_r;
  logic periph_en_nxt;
  logic tick_req_r;
  logic tick_req_nxt;
  logic irq_r;
  logic irq_nxt;

  // Decode
  logic [mcts_pkg::IDX_W-1:0] idx;
  logic aligned;
  logic req_any;
  logic acc;
  logic wr_acc;
  logic rd_acc;
  logic csr_rd_clr;
  logic frozen;
  logic tick_run;
  logic core_run;
  logic cpu_end;
  logic tick_end;
  logic wake;
  logic [mcts_pkg::CPU_DIV_W-1:0] cpu_lim;
  logic [mcts_pkg::TICK_W-1:0] tick_lim;

  assign idx = req.address[mcts_pkg::ADDR_W-1:2];
  assign aligned = (req.address[1:0] == mcts_pkg::ADDR_LSB_ZERO);
  assign req_any = req.read || req.write;
  // Request completes on the edge where waitrequest is low
  assign acc = req_any && ack_r;
  assign wr_acc = acc && req.write && req.byteenable[0] && aligned;
  assign rd_acc = acc && req.read && aligned;
  // A read clears the flag only if the data it returns showed the flag set,
  // so a tick landing on the snapshot edge is not lost
  assign csr_rd_clr = rd_acc && !frozen && (idx == mcts_pkg::CSR_IDX) && rdata_r[0];
  assign avs_waitrequest_out = req_any && !ack_r;
  assign avs_readdata_out = rdata_r;

  // Bus writes and flag-clearing reads are ignored in deep sleep and both halts
  assign frozen = (mode_r == mcts_pkg::PM_DEEP) || (mode_r == mcts_pkg::PM_HALT) ||
                  (mode_r == mcts_pkg::PM_AWU);
  assign tick_run = (mode_r != mcts_pkg::PM_HALT) && (mode_r != mcts_pkg::PM_AWU);
  assign core_run = tick_run;

  // CPU prescaler limit
  always_comb begin
    cpu_lim = mcts_pkg::CPU_DIV1_LIM;
    if (csr_r.slow_mode_select) begin
      unique case (csr_r.cpu_slow_divider_select)
        2'b00: cpu_lim = mcts_pkg::CPU_DIV2_LIM;
        2'b01: cpu_lim = mcts_pkg::CPU_DIV4_LIM;
        2'b10: cpu_lim = mcts_pkg::CPU_DIV8_LIM;
        2'b11: cpu_lim = mcts_pkg::CPU_DIV16_LIM;
      endcase
    end
  end

  // Tick limit follows the latched time base, not the live field
  always_comb begin
    unique case (active_tb_r)
      2'b00: tick_lim = mcts_pkg::TICK_W'(TB0_CYC - 1);
      2'b01: tick_lim = mcts_pkg::TICK_W'(TB1_CYC - 1);
      2'b10: tick_lim = mcts_pkg::TICK_W'(TB2_CYC - 1);
      2'b11: tick_lim = mcts_pkg::TICK_W'(TB3_CYC - 1);
    endcase
  end

  // Separate counters so no function limits another
  mcts_div #(
    .W(mcts_pkg::CPU_DIV_W)
  ) u_cpu_div (
    .core_clk_in(core_clk_in),
    .srst_in(srst_in),
    .run_in(core_run),
    .limit_in(cpu_lim),
    .end_out(cpu_end)
  );

  mcts_div #(
    .W(mcts_pkg::TICK_W)
  ) u_tick_div (
    .core_clk_in(core_clk_in),
    .srst_in(srst_in),
    .run_in(tick_run),
    .limit_in(tick_lim),
    .end_out(tick_end)
  );

  // Time base latch
  always_comb begin
    active_tb_nxt = active_tb_r;
    if (tick_end) begin
      active_tb_nxt = csr_r.time_base_select;
    end
  end

  // Control/status register
  always_comb begin
    csr_nxt = csr_r;
    if (wr_acc && !frozen && (idx == mcts_pkg::CSR_IDX)) begin
      csr_nxt.clock_out_enable = req.writedata[7];
      csr_nxt.cpu_slow_divider_select = req.writedata[6:5];
      csr_nxt.slow_mode_select = req.writedata[4];
      csr_nxt.time_base_select = req.writedata[3:2];
      csr_nxt.tick_interrupt_enable = req.writedata[1];
    end
    if (csr_rd_clr) begin
      csr_nxt.tick_flag = 1'b0;
    end
    if (tick_end) begin
      csr_nxt.tick_flag = 1'b1;
    end
  end

  // Interrupt status, clear and enable
  always_comb begin
    irq_stat_nxt = irq_stat_r;
    irq_en_nxt = irq_en_r;
    if (wr_acc && !frozen && (idx == mcts_pkg::IRQ_CLR_IDX)) begin
      irq_stat_nxt = irq_stat_r & ~req.writedata[mcts_pkg::IRQ_W-1:0];
    end
    if (wr_acc && !frozen && (idx == mcts_pkg::IRQ_EN_IDX)) begin
      irq_en_nxt = req.writedata[mcts_pkg::IRQ_W-1:0];
    end
    if (tick_end) begin
      irq_stat_nxt[mcts_pkg::IRQ_TICK_BIT] = 1'b1;
    end
    if (wake) begin
      irq_stat_nxt[mcts_pkg::IRQ_WAKE_BIT] = 1'b1;
    end
  end

  // Power mode sequencing
  always_comb begin
    mode_nxt = mode_r;
    wake = 1'b0;
    unique case (mode_r)
      mcts_pkg::PM_RUN: begin
        if (halt_exec_in) begin
          mode_nxt = csr_r.tick_interrupt_enable ? mcts_pkg::PM_DEEP : mcts_pkg::PM_HALT;
        end else if (awu_halt_exec_in) begin
          mode_nxt = mcts_pkg::PM_AWU;
        end else if (wait_exec_in) begin
          mode_nxt = mcts_pkg::PM_WAIT;
        end
      end
      mcts_pkg::PM_WAIT: begin
        wake = tick_req_r || other_irq_in;
      end
      mcts_pkg::PM_DEEP: begin
        wake = tick_req_r || halt_wake_in;
      end
      // A pending tick request stays pending through either halt
      mcts_pkg::PM_HALT, mcts_pkg::PM_AWU: begin
        wake = halt_wake_in;
      end
      default: begin
        mode_nxt = mcts_pkg::PM_RUN;
      end
    endcase
    if (wake) begin
      mode_nxt = mcts_pkg::PM_RUN;
    end
  end

  // Bus answer: one wait cycle, data ready when waitrequest drops
  always_comb begin
    ack_nxt = req_any && !ack_r;
    rdata_nxt = rdata_r;
    if (req.read && !ack_r) begin
      rdata_nxt = '0;
      if (aligned) begin
        unique case (idx)
          mcts_pkg::CSR_IDX: rdata_nxt[7:0] = csr_r;
          mcts_pkg::IRQ_STAT_IDX: rdata_nxt[mcts_pkg::IRQ_W-1:0] = irq_stat_r;
          mcts_pkg::IRQ_EN_IDX: rdata_nxt[mcts_pkg::IRQ_W-1:0] = irq_en_r;
          mcts_pkg::PMODE_IDX: rdata_nxt[2:0] = mode_r;
          default: rdata_nxt = '0;
        endcase
      end
    end
  end

  // Output enables and requests; both clock enables follow the next mode,
  // so the peripheral pulse never lags the CPU pulse across a wake
  always_comb begin
    cpu_en_nxt = cpu_end && (mode_nxt == mcts_pkg::PM_RUN);
    periph_en_nxt = cpu_end && ((mode_nxt == mcts_pkg::PM_RUN) || (mode_nxt == mcts_pkg::PM_WAIT));
    tick_req_nxt = csr_nxt.tick_flag && csr_nxt.tick_interrupt_enable;
    irq_nxt = |(irq_stat_nxt & irq_en_nxt);
  end

  // Clock-out pin, shared with general-purpose use
  assign clk_pin_out = csr_r.clock_out_enable ? core_clk_in : gpio_pin_data_in;
  assign clk_pin_oe_out = csr_r.clock_out_enable || gpio_pin_oe_in;

  assign cpu_clk_en_out = cpu_en_r;
  assign periph_clk_en_out = periph_en_r;
  assign tick_req_out = tick_req_r;
  assign irq_out = irq_r;
  assign power_mode_out = mode_r;

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      csr_r <= mcts_pkg::CSR_RST;
      active_tb_r <= 2'h0;
      irq_stat_r <= mcts_pkg::IRQ_RST;
      irq_en_r <= mcts_pkg::IRQ_RST;
      mode_r <= mcts_pkg::PM_RUN;
      ack_r <= 1'b0;
      rdata_r <= '0;
      cpu_en_r <= 1'b0;
      periph_en_r <= 1'b0;
      tick_req_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      csr_r <= csr_nxt;
      active_tb_r <= active_tb_nxt;
      irq_stat_r <= irq_stat_nxt;
      irq_en_r <= irq_en_nxt;
      mode_r <= mode_nxt;
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
      cpu_en_r <= cpu_en_nxt;
      periph_en_r <= periph_en_nxt;
      tick_req_r <= tick_req_nxt;
      irq_r <= irq_nxt;
    end
  end

endmodule // mcts_top

// [dv/mcts_top_props.sv]
// Purpose: Port assertions for the clock and tick controller
// Assumes: One clock, synchronous active-high reset
// Notes: Bound to every instance of the top
module mcts_top_props (
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic avs_waitrequest_out,
  input wire logic [mcts_pkg::DATA_W-1:0] avs_readdata_out,
  input wire logic halt_exec_in,
  input wire logic halt_wake_in,
  input wire logic gpio_pin_data_in,
  input wire logic clk_pin_out,
  input wire logic clk_pin_oe_out,
  input wire logic cpu_clk_en_out,
  input wire logic periph_clk_en_out,
  input wire logic tick_req_out,
  input wire logic irq_out,
  input wire mcts_pkg::mcts_pmode_t power_mode_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic run;
  logic wt;
  logic hlt;
  logic slp;
  assign run = power_mode_out == mcts_pkg::PM_RUN;
  assign wt = power_mode_out == mcts_pkg::PM_WAIT;
  assign hlt = power_mode_out inside {mcts_pkg::PM_HALT, mcts_pkg::PM_AWU};
  assign slp = !run && !wt;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (srst_in);
  a_bus_one_wait: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("bus wait too long");
  a_pin_gpio: assert property (!clk_pin_oe_out |-> clk_pin_out == gpio_pin_data_in)
    else $error("pin not free for gpio");
  a_wait_tick_wake: assert property (wt && tick_req_out |=> run)
    else $error("tick did not end wait");
  a_deep_tick_wake: assert property (slp && !hlt && tick_req_out |=> run)
    else $error("tick did not end deep sleep");
  a_halt_held: assert property (hlt && !halt_wake_in |=> $stable(power_mode_out))
    else $error("halt left without wake");
  a_halt_entry: assert property (run && halt_exec_in |=> power_mode_out inside {mcts_pkg::PM_DEEP, mcts_pkg::PM_HALT})
    else $error("halt not entered");
  a_sleep_cpu_off: assert property (!run [*2] |-> !cpu_clk_en_out)
    else $error("cpu clock in low power");
  a_sleep_per_off: assert property (slp [*2] |-> !periph_clk_en_out)
    else $error("peripheral clock in sleep");
  a_cpu_in_per: assert property (cpu_clk_en_out |-> periph_clk_en_out)
    else $error("cpu pulse without peripheral pulse");
  a_reset_quiet: assert property ($fell(srst_in) |-> !tick_req_out && !irq_out && run && avs_readdata_out == '0)
    else $error("outputs not cleared by reset");
  c_wait: cover property (wt);
  c_deep: cover property (slp && !hlt && tick_req_out);
  c_halt: cover property (hlt ##1 run);
  c_irq: cover property (irq_out);
endmodule // mcts_top_props

bind mcts_top mcts_top_props i_mcts_top_props (.*);

// [dv/mcts_cpu_model.sv]
// Purpose: CPU side issuing wait and halt instructions
// Assumes: op_in is a one-cycle request code from the bench
// Notes: An instruction only executes on a CPU clock enable
module mcts_cpu_model (
  input wire logic core_clk_in,
  input wire logic cpu_clk_en_in,
  input wire logic [1:0] op_in,
  output logic wait_exec_out,
  output logic halt_exec_out,
  output logic awu_halt_exec_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] pend = 2'h0;
  initial {wait_exec_out, halt_exec_out, awu_halt_exec_out} = 3'h0;
  always @(posedge core_clk_in) begin
    {wait_exec_out, halt_exec_out, awu_halt_exec_out} <= 3'h0;
    if (op_in != 2'h0) begin
      pend <= op_in;
    end else if (cpu_clk_en_in && pend != 2'h0) begin
      wait_exec_out <= pend == 2'h1;
      halt_exec_out <= pend == 2'h2;
      awu_halt_exec_out <= pend == 2'h3;
      pend <= 2'h0;
    end
  end
endmodule // mcts_cpu_model

// [dv/tb_mcts_top.sv]
// Purpose: Self-checking bench for the clock and tick controller
// Assumes: Tick periods shortened to 8, 12, 16 and 20 cycles
// Notes: Expected periods come from a table in the bench
module tb_mcts_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] A_C = {mcts_pkg::CSR_IDX, 2'h0};
  localparam logic [7:0] A_S = {mcts_pkg::IRQ_STAT_IDX, 2'h0};
  localparam logic [7:0] A_L = {mcts_pkg::IRQ_CLR_IDX, 2'h0};
  localparam logic [7:0] A_E = {mcts_pkg::IRQ_EN_IDX, 2'h0};
  logic core_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic oirq = 1'b0;
  logic hwake = 1'b0;
  logic gdat = 1'b0;
  logic goe = 1'b0;
  logic [1:0] op = 2'h0;
  logic wq, we, he, ae, pin, pin_oe, cpu_en, per_en, treq, irq;
  mcts_pkg::mcts_pmode_t mode;
  int seed = 32'h9e15;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;
  int t0, t1, nc, old;
  int per[4] = '{8, 12, 16, 20};
  int seq[4] = '{1, 2, 0, 3};

  mcts_top #(.TB0_CYC(8), .TB1_CYC(12), .TB2_CYC(16), .TB3_CYC(20)) i_mcts_top (
    .core_clk_in(core_clk_in), .srst_in(srst_in), .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wdat), .avs_byteenable_in(4'hf), .avs_readdata_out(rdat), .avs_waitrequest_out(wq),
    .wait_exec_in(we), .halt_exec_in(he), .awu_halt_exec_in(ae), .other_irq_in(oirq), .halt_wake_in(hwake),
    .gpio_pin_data_in(gdat), .gpio_pin_oe_in(goe), .clk_pin_out(pin), .clk_pin_oe_out(pin_oe),
    .cpu_clk_en_out(cpu_en), .periph_clk_en_out(per_en), .tick_req_out(treq), .irq_out(irq), .power_mode_out(mode));
  mcts_cpu_model i_mcts_cpu_model (.core_clk_in(core_clk_in), .cpu_clk_en_in(cpu_en), .op_in(op),
    .wait_exec_out(we), .halt_exec_out(he), .awu_halt_exec_out(ae));

  initial forever #20 core_clk_in = ~core_clk_in;

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  always @(posedge core_clk_in) begin
    cyc <= cyc + 1;
    if (cyc > 4000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      $display("[ERR] %s exp %h seen %h", nm, e, s);
      n_mismatch++;
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
    @(posedge core_clk_in);
    adr <= a;
    wr <= w;
    rd <= !w;
    wdat <= {24'($random(seed)), d};
    do begin
      @(posedge core_clk_in);
    end while (wq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic wrr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk("rdata", q, e);
  endtask

  task automatic wfor(input logic tk, input mcts_pkg::mcts_pmode_t m);
    int n = 0;
    do begin
      @(negedge core_clk_in);
      n++;
    end while ((tk ? treq !== 1'b1 : mode !== m) && n < 400);
    t1 = cyc;
    if (!tk) chk("mode", mode, m);
  endtask

  task automatic exec(input logic [1:0] k);
    @(posedge core_clk_in);
    op <= k;
    @(posedge core_clk_in);
    op <= 2'h0;
  endtask

  initial begin
    logic [7:0] v;
    repeat (6) @(posedge core_clk_in);
    srst_in <= 1'b0;
    rc(A_C, 32'h0);
    rc(A_E, 32'h0);
    rc(8'hfc, 32'h0);
    $display("test reset done");
    for (int cp = -1; cp < 4; cp++) begin
      v = cp < 0 ? 8'h80 : {cp[0], 2'(cp), 5'h10};
      @(posedge core_clk_in);
      {goe, gdat} <= 2'($random(seed));
      wrr(A_C, v);
      repeat (3) @(negedge core_clk_in);
      nc = 0;
      repeat (64) begin
        @(negedge core_clk_in);
        nc += cpu_en;
      end
      chk("cpu_en", nc, cp < 0 ? 64 : 64 >> (cp + 1));
      #5;
      chk("pin", {pin_oe, pin}, v[7] ? 2'h2 : {goe, gdat});
      chk("treq", treq, 0);
    end
    $display("test clock done");
    wrr(A_C, 8'h02);
    rc(A_C, 32'h3);
    wfor(1'b1, mcts_pkg::PM_RUN);
    t0 = t1;
    rc(A_C, 32'h3);
    old = 0;
    for (int i = 0; i < 4; i++) begin
      wrr(A_C, {4'h0, 2'(seq[i]), 2'h2});
      wfor(1'b1, mcts_pkg::PM_RUN);
      chk("old_per", t1 - t0, per[old]);
      rc(A_C, {4'h0, 2'(seq[i]), 2'h3});
      t0 = t1;
      wfor(1'b1, mcts_pkg::PM_RUN);
      chk("new_per", t1 - t0, per[seq[i]]);
      if (i == 3) begin
        wrr(A_E, 8'h01);
        repeat (2) @(negedge core_clk_in);
        chk("irq", irq, 1);
        wrr(A_E, 8'h00);
        repeat (2) @(negedge core_clk_in);
        chk("irq", irq, 0);
        wrr(A_L, 8'h01);
        rc(A_S, 32'h0);
      end
      rc(A_C, {4'h0, 2'(seq[i]), 2'h3});
      t0 = t1;
      old = seq[i];
    end
    $display("test tick done");
    exec(2'h1);
    wfor(1'b0, mcts_pkg::PM_WAIT);
    wfor(1'b0, mcts_pkg::PM_RUN);
    rc(A_C, 32'hf);
    exec(2'h2);
    wfor(1'b0, mcts_pkg::PM_DEEP);
    wfor(1'b0, mcts_pkg::PM_RUN);
    rc(A_C, 32'hf);
    for (int k = 2; k < 4; k++) begin
      wrr(A_C, k == 2 ? 8'h0c : 8'h0e);
      if (k == 3) begin
        wfor(1'b1, mcts_pkg::PM_RUN);
        @(posedge core_clk_in);
      end
      oirq <= 1'b1;
      exec(2'(k));
      wfor(1'b0, k == 2 ? mcts_pkg::PM_HALT : mcts_pkg::PM_AWU);
      repeat (50) @(negedge core_clk_in);
      chk("mode", mode, k == 2 ? mcts_pkg::PM_HALT : mcts_pkg::PM_AWU);
      @(posedge core_clk_in);
      hwake <= 1'b1;
      oirq <= 1'b0;
      wfor(1'b0, mcts_pkg::PM_RUN);
      @(posedge core_clk_in);
      hwake <= 1'b0;
    end
    rc(A_S, 32'h3);
    rc(8'hd0, 32'h0);
    $display("test power done");
    give_verdict();
  end
endmodule // tb_mcts_top
